// ### src/fpcc_div_pkg.sv
package fpcc_div_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_OPWORD = 8'h00;
    localparam logic [7:0] OFF_FPCC = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_DST_EXP = 8'h0c;
    localparam logic [7:0] OFF_DST_MAN = 8'h10;
    localparam logic [7:0] OFF_SRC_EXP = 8'h14;
    localparam logic [7:0] OFF_SRC_MAN = 8'h18;
    localparam logic [7:0] OFF_CMD = 8'h1c;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    localparam logic [7:0] OFF_RESULT = 8'h24;

    // command bits
    localparam int CMD_SET_BIT = 0;
    localparam int CMD_DIV_BIT = 1;

    // condition code bits
    localparam int COND_N = 3;
    localparam int COND_Z = 2;
    localparam int COND_I = 1;
    localparam int COND_NAN = 0;

    // exception byte and accrued bits
    localparam int EXC_UNORD = 7;
    localparam int EXC_OPND_ERR = 5;
    localparam int EXC_DIV_ZERO = 3;
    localparam int ACC_IOP = 4;
    localparam int ACC_DIV_ZERO = 1;

    // status word layout
    localparam int STAT_EXC_LSB = 8;
    localparam int STAT_ACC_LSB = 3;
    localparam int STAT_TRAP_BIT = 2;
    localparam int STAT_ILL_BIT = 1;

    localparam logic [14:0] EXP_BIAS = 15'h3fff;
    localparam logic [14:0] EXP_MAX = 15'h7fff;
    localparam logic [23:0] NAN_MAN = 24'hffffff;
    localparam logic [23:0] ONE_MAN = 24'h800000;
    localparam logic [4:0] DIV_STEPS = 5'h1b;

    typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_ROUND} state_t;

    typedef struct packed {
        logic sign;
        logic [14:0] exp;
        logic [23:0] man;
    } fp_t;

    typedef struct packed {
        logic [31:0] opword;
        logic [3:0] fpcc;
        logic trap_en;
        fp_t dst;
        fp_t src;
        logic [7:0] exc;
        logic [4:0] acc;
        logic trap;
        logic illegal;
        logic [7:0] result;
        state_t state;
        logic [4:0] cnt;
        logic [24:0] rem;
        logic [26:0] quo;
        logic [16:0] rexp;
        logic rsign;
        logic we;
        logic [5:0] ea;
        logic trap_pulse;
    } core_t;

    localparam core_t CORE_RST = '0;

endpackage : fpcc_div_pkg

// ### src/fp_cond_divide.sv
// Operation
// [RQ1] a conditional set writes the byte destination as all ones when true, all zeros if false.
// [RQ2] the predicate picks one of thirty-two tests against the condition codes.
// [RQ3] a NaN code with a test that is not IEEE-aware sets the unordered-branch flag.
// [RQ4] setting the unordered-branch flag also sets the accrued invalid-operation bit.
// [RQ5] only data-alterable destination modes are accepted, others are rejected.
// [RQ6] an enabled unordered-branch trap is taken before the destination is written.
// [RQ7] a handler returning to the same set must clear the NaN code or the trap enable first.
// [RQ8] the single divide divides the destination by the source and stores it back.
// [RQ9] the quotient mantissa rounds to single width, the exponent keeps extended range.
// [RQ10] operand mantissa bits beyond single width are dropped before dividing.
// [RQ11] in-range over zero gives an infinity of the xor sign and sets divide-by-zero.
// [RQ12] zero over zero or infinity over infinity gives NaN and sets operand error.
// [RQ13] the quotient exponent is not clamped to the single-precision range.
// [RQ14] the set is decoded from a coprocessor first word and an extension word.
`timescale 1ns/1ps
module fp_cond_divide
    import fpcc_div_pkg::*;
#(
    parameter logic [2:0] COPROC_ID = 3'h1
) (
    input wire logic MCLK_I,
    input wire logic RESET_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    output logic DEST_WE_O,
    output logic [7:0] DEST_BYTE_O,
    output logic [5:0] DEST_EA_O,
    output logic FP_TRAP_O,
    output logic BUSY_O
);

    localparam int A_DIV_LAT = 29;

    core_t core_q;
    core_t core_d;

    logic addr_ok;
    logic wr_q;
    logic wr_d;
    logic rd_q;
    logic rd_d;
    logic [7:0] baddr_q;
    logic [7:0] baddr_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] status_w;

    logic [15:0] op_w;
    logic [15:0] ext_w;
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
    logic decode_ok;
    logic ea_ok;
    logic cond;
    logic unord;
    logic cmd_wr;
    logic set_go;
    logic div_go;
    logic stat_wr;

    logic d_zero;
    logic s_zero;
    logic d_inf;
    logic s_inf;
    logic d_nan;
    logic s_nan;
    logic res_sign;

    logic ge;
    logic [24:0] diff;
    logic norm;
    logic [23:0] m;
    logic rnd;
    logic stk;
    logic [24:0] m25;
    logic [16:0] e;

    function automatic logic cond_eval(input logic [3:0] code, input logic [3:0] codes);
        logic n;
        logic z;
        logic u;
        n = codes[COND_N];
        z = codes[COND_Z];
        u = codes[COND_NAN];
        case (code)
            4'h0: return 1'b0;
            4'h1: return z;
            4'h2: return !(u || z || n);
            4'h3: return z || !(u || n);
            4'h4: return n && !(u || z);
            4'h5: return z || (n && !u);
            4'h6: return !(u || z);
            4'h7: return !u;
            4'h8: return u;
            4'h9: return u || z;
            4'ha: return u || !(n || z);
            4'hb: return u || z || !n;
            4'hc: return u || (n && !z);
            4'hd: return u || z || n;
            4'he: return !z;
            default: return 1'b1;
        endcase
    endfunction : cond_eval

    // bus slave: writes take no wait, reads one wait state
    assign addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];

    assign status_w = {16'h0, core_q.exc, core_q.acc, core_q.trap, core_q.illegal,
                       core_q.state != ST_IDLE};

    always_comb begin
        wr_d = addr_ok && HWRITE_I;
        rd_d = addr_ok && !HWRITE_I;
        baddr_d = addr_ok ? HADDR_I[7:0] : baddr_q;
        rdata_d = rdata_q;
        // read sampled a cycle late so a preceding write is seen
        if (rd_q) begin
            case (baddr_q)
                OFF_OPWORD: rdata_d = core_q.opword;
                OFF_FPCC: rdata_d = {28'h0, core_q.fpcc};
                OFF_CTRL: rdata_d = {31'h0, core_q.trap_en};
                OFF_DST_EXP: rdata_d = {16'h0, core_q.dst.sign, core_q.dst.exp};
                OFF_DST_MAN: rdata_d = {core_q.dst.man, 8'h0};
                OFF_SRC_EXP: rdata_d = {16'h0, core_q.src.sign, core_q.src.exp};
                OFF_SRC_MAN: rdata_d = {core_q.src.man, 8'h0};
                OFF_STATUS: rdata_d = status_w;
                OFF_RESULT: rdata_d = {24'h0, core_q.result};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            baddr_q <= 8'h0;
            rdata_q <= 32'h0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            baddr_q <= baddr_d;
            rdata_q <= rdata_d;
        end
    end

    // [RQ14] opcode decode
    assign op_w = core_q.opword[15:0];
    assign ext_w = core_q.opword[31:16];
    assign ea_mode = op_w[5:3];
    assign ea_reg = op_w[2:0];
    assign decode_ok = (op_w[15:12] == 4'hf) && (op_w[11:9] == COPROC_ID)
                       && (op_w[8:6] == 3'h1) && (ext_w[15:5] == 11'h0);
    // [RQ5] data-alterable modes only
    assign ea_ok = (ea_mode != 3'h1) && !((ea_mode == 3'h7) && (ea_reg[2:1] != 2'h0));
    // [RQ2] one of thirty-two tests
    assign cond = cond_eval(ext_w[3:0], core_q.fpcc);
    // [RQ3] upper half of the tests is not IEEE-aware
    assign unord = core_q.fpcc[COND_NAN] && ext_w[4];

    assign cmd_wr = wr_q && (baddr_q == OFF_CMD) && (core_q.state == ST_IDLE);
    assign set_go = cmd_wr && HWDATA_I[CMD_SET_BIT];
    assign div_go = cmd_wr && HWDATA_I[CMD_DIV_BIT] && !HWDATA_I[CMD_SET_BIT];
    assign stat_wr = wr_q && (baddr_q == OFF_STATUS);

    assign d_zero = (core_q.dst.exp == 15'h0) && (core_q.dst.man == 24'h0);
    assign s_zero = (core_q.src.exp == 15'h0) && (core_q.src.man == 24'h0);
    assign d_inf = (core_q.dst.exp == EXP_MAX) && (core_q.dst.man == 24'h0);
    assign s_inf = (core_q.src.exp == EXP_MAX) && (core_q.src.man == 24'h0);
    assign d_nan = (core_q.dst.exp == EXP_MAX) && (core_q.dst.man != 24'h0);
    assign s_nan = (core_q.src.exp == EXP_MAX) && (core_q.src.man != 24'h0);
    assign res_sign = core_q.dst.sign ^ core_q.src.sign;

    // restoring divide step and final rounding
    always_comb begin
        diff = core_q.rem - {1'b0, core_q.src.man};
        ge = core_q.rem >= {1'b0, core_q.src.man};
        norm = core_q.quo[26];
        m = norm ? core_q.quo[26:3] : core_q.quo[25:2];
        rnd = norm ? core_q.quo[2] : core_q.quo[1];
        stk = (norm ? |core_q.quo[1:0] : core_q.quo[0]) || (|core_q.rem);
        // [RQ9] nearest-even at single width, control precision not consulted
        m25 = {1'b0, m} + {24'h0, rnd && (stk || m[0])};
        // [RQ13] exponent kept wide, no single-range clamp
        e = core_q.rexp + {16'h0, m25[24]} - {16'h0, !norm};
    end

    always_comb begin
        core_d = core_q;
        core_d.we = 1'b0;
        core_d.trap_pulse = 1'b0;
        // operands frozen while a divide runs
        if (wr_q && core_q.state == ST_IDLE) begin
            case (baddr_q)
                OFF_OPWORD: core_d.opword = HWDATA_I;
                // [RQ7] software clears the NaN code here to stop a repeat trap
                OFF_FPCC: core_d.fpcc = HWDATA_I[3:0];
                OFF_CTRL: core_d.trap_en = HWDATA_I[0];
                OFF_DST_EXP: {core_d.dst.sign, core_d.dst.exp} = HWDATA_I[15:0];
                // [RQ10] low mantissa bits dropped on entry
                OFF_DST_MAN: core_d.dst.man = HWDATA_I[31:8];
                OFF_SRC_EXP: {core_d.src.sign, core_d.src.exp} = HWDATA_I[15:0];
                OFF_SRC_MAN: core_d.src.man = HWDATA_I[31:8];
                default: ;
            endcase
        end
        // write-one-to-clear, applied before hardware sets so a set wins
        if (stat_wr) begin
            core_d.exc = core_q.exc & ~HWDATA_I[STAT_EXC_LSB +: 8];
            core_d.acc = core_q.acc & ~HWDATA_I[STAT_ACC_LSB +: 5];
            core_d.trap = core_q.trap && !HWDATA_I[STAT_TRAP_BIT];
            core_d.illegal = core_q.illegal && !HWDATA_I[STAT_ILL_BIT];
        end
        if (set_go) begin
            if (!(decode_ok && ea_ok)) begin
                core_d.illegal = 1'b1;
            end else begin
                if (unord) begin
                    // [RQ3] unordered-branch flag
                    core_d.exc[EXC_UNORD] = 1'b1;
                    // [RQ4] accrued invalid operation
                    core_d.acc[ACC_IOP] = 1'b1;
                end
                // [RQ6] enabled trap blocks the write
                if (unord && core_q.trap_en) begin
                    core_d.trap = 1'b1;
                    core_d.trap_pulse = 1'b1;
                end else begin
                    // [RQ1] byte of all ones or all zeros
                    core_d.result = {8{cond}};
                    core_d.ea = op_w[5:0];
                    core_d.we = 1'b1;
                end
            end
        end else if (div_go) begin
            core_d.exc[EXC_UNORD] = 1'b0;
            core_d.exc[EXC_OPND_ERR] = 1'b0;
            core_d.exc[EXC_DIV_ZERO] = 1'b0;
            if (d_nan || s_nan) begin
                core_d.dst = '{sign: 1'b0, exp: EXP_MAX, man: NAN_MAN};
            end else if ((d_zero && s_zero) || (d_inf && s_inf)) begin
                // [RQ12] invalid quotient
                core_d.dst = '{sign: 1'b0, exp: EXP_MAX, man: NAN_MAN};
                core_d.exc[EXC_OPND_ERR] = 1'b1;
                core_d.acc[ACC_IOP] = 1'b1;
            end else if (d_inf || s_zero) begin
                core_d.dst = '{sign: res_sign, exp: EXP_MAX, man: 24'h0};
                if (s_zero && !d_inf) begin
                    // [RQ11] divide by zero
                    core_d.exc[EXC_DIV_ZERO] = 1'b1;
                    core_d.acc[ACC_DIV_ZERO] = 1'b1;
                end
            end else if (d_zero || s_inf) begin
                core_d.dst = '{sign: res_sign, exp: 15'h0, man: 24'h0};
            end else begin
                // [RQ8] start the mantissa divide
                core_d.state = ST_DIV;
                core_d.cnt = DIV_STEPS - 5'h1;
                core_d.rem = {1'b0, core_q.dst.man};
                core_d.quo = 27'h0;
                core_d.rsign = res_sign;
                core_d.rexp = {2'h0, core_q.dst.exp} - {2'h0, core_q.src.exp}
                              + {2'h0, EXP_BIAS};
            end
        end
        case (core_q.state)
            ST_DIV: begin
                core_d.quo = {core_q.quo[25:0], ge};
                core_d.rem = ge ? {diff[23:0], 1'b0} : {core_q.rem[23:0], 1'b0};
                core_d.cnt = core_q.cnt - 5'h1;
                if (core_q.cnt == 5'h0) begin
                    core_d.state = ST_ROUND;
                end
            end
            ST_ROUND: begin
                // [RQ8] quotient back into the destination
                core_d.dst.sign = core_q.rsign;
                core_d.dst.exp = e[14:0];
                core_d.dst.man = m25[24] ? ONE_MAN : m25[23:0];
                core_d.state = ST_IDLE;
            end
            default: ;
        endcase
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            core_q <= CORE_RST;
        end else begin
            core_q <= core_d;
        end
    end

    assign HRDATA_O = rdata_q;
    assign HREADYOUT_O = !rd_q;
    assign HRESP_O = 1'b0;
    assign DEST_WE_O = core_q.we;
    assign DEST_BYTE_O = core_q.result;
    assign DEST_EA_O = core_q.ea;
    assign FP_TRAP_O = core_q.trap_pulse;
    assign BUSY_O = core_q.state != ST_IDLE;

    default clocking @(posedge MCLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    a_set_byte_form: assert property ( // [RQ1]
        DEST_WE_O |-> (DEST_BYTE_O == 8'hff) || (DEST_BYTE_O == 8'h00))
        else $error("set byte not all ones or zeros");

    a_pred_equal_test: assert property ( // [RQ2]
        set_go && decode_ok && ea_ok && !unord && (ext_w[3:0] == 4'h1)
        |=> DEST_WE_O && (DEST_BYTE_O[0] == $past(core_q.fpcc[COND_Z])))
        else $error("equal test gave wrong byte");

    a_unord_sets_flag: assert property ( // [RQ3]
        set_go && decode_ok && ea_ok && core_q.fpcc[COND_NAN] && ext_w[4]
        |=> core_q.exc[EXC_UNORD])
        else $error("unordered flag not set");

    a_accrued_iop: assert property ( // [RQ4]
        $rose(core_q.exc[EXC_UNORD]) |-> core_q.acc[ACC_IOP])
        else $error("accrued invalid bit missing");

    a_ea_reject: assert property ( // [RQ5]
        set_go && (ea_mode == 3'h1) |=> core_q.illegal && !DEST_WE_O)
        else $error("address register mode accepted");

    a_trap_no_write: assert property ( // [RQ6]
        set_go && decode_ok && ea_ok && unord && core_q.trap_en
        |=> FP_TRAP_O && !DEST_WE_O)
        else $error("trap did not block write");

    a_div_latency: assert property ( // [RQ8]
        div_go && !(d_zero || s_zero || d_inf || s_inf || d_nan || s_nan)
        |-> ##A_DIV_LAT (core_q.state == ST_IDLE) && $past(core_q.state) == ST_ROUND)
        else $error("divide did not finish on time");

    a_round_norm: assert property ( // [RQ9]
        core_q.state == ST_ROUND |=> core_q.dst.man[23])
        else $error("quotient not normalized");

    a_div_zero: assert property ( // [RQ11]
        div_go && s_zero && !(d_zero || d_inf || d_nan)
        |=> core_q.exc[EXC_DIV_ZERO] && core_q.dst.exp == EXP_MAX && core_q.dst.man == 24'h0
            && core_q.dst.sign == $past(res_sign))
        else $error("divide by zero result wrong");

    a_operand_error: assert property ( // [RQ12]
        div_go && ((d_zero && s_zero) || (d_inf && s_inf))
        |=> core_q.exc[EXC_OPND_ERR] && core_q.dst.man != 24'h0)
        else $error("invalid divide not flagged");

endmodule : fp_cond_divide

// ### verification/fpcc_host_model.sv
`timescale 1ns/1ps
module fpcc_host_model
    import fpcc_div_pkg::*;
(
    input wire logic clk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [31:0] hwdata_o
);
    initial begin
        hsel_o = 1'b0;
        haddr_o = '0;
        htrans_o = 2'b00;
        hwrite_o = 1'b0;
        hwdata_o = '0;
    end

    // entered just after a rising edge; a stalled slave is waited out
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel_o <= 1'b1;
        haddr_o <= {24'h0, a};
        htrans_o <= 2'b10;
        hwrite_o <= w;
        // stale data bus flips so nothing can rely on it
        hwdata_o <= ~hwdata_o;
        @(posedge clk_i);
        while (hready_i !== 1'b1) @(posedge clk_i);
        hsel_o <= 1'b0;
        htrans_o <= 2'b00;
        hwdata_o <= d;
        @(posedge clk_i);
        while (hready_i !== 1'b1) @(posedge clk_i);
        q = hrdata_i;
    endtask : xfer

    task automatic retry_set();
        logic [31:0] q;
        xfer(1'b1, OFF_FPCC, 32'h0, q);
        xfer(1'b1, OFF_CMD, 32'h1, q);
    endtask : retry_set
endmodule : fpcc_host_model

// ### verification/fp_cond_divide_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    begin \
        n_checks++; \
        if ((got) !== (ex)) begin \
            bad_count++; \
            $display("[ERR] %s expected %h seen %h", nm, ex, got); \
        end \
    end
module fp_cond_divide_tb_top;
    import fpcc_div_pkg::*;
    logic mclk;
    logic rst_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic dwe;
    logic [7:0] dbyte;
    logic [5:0] dea;
    logic trap;
    logic busy;
    logic [7:0] last_byte;
    logic [5:0] last_ea;
    logic [31:0] rv;
    int bad_count = 0;
    int n_checks = 0;
    int we_n = 0;
    int trap_n = 0;

    fp_cond_divide #(.COPROC_ID(3'h1)) u_fp_cond_divide (
        .MCLK_I(mclk), .RESET_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .DEST_WE_O(dwe), .DEST_BYTE_O(dbyte), .DEST_EA_O(dea), .FP_TRAP_O(trap),
        .BUSY_O(busy));

    fpcc_host_model u_fpcc_host_model (
        .clk_i(mclk), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
        .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // pulses last one cycle, so they are counted rather than polled
    always @(posedge mclk) begin
        if (dwe === 1'b1) begin
            we_n++;
            last_byte = dbyte;
            last_ea = dea;
        end
        if (trap === 1'b1) trap_n++;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_fpcc_host_model.xfer(1'b1, a, d, rv);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        u_fpcc_host_model.xfer(1'b0, a, 32'h0, rv);
    endtask : rd

    function automatic logic [31:0] opw(input logic [5:0] ea, input logic [5:0] pr);
        return {10'h0, pr, 4'hf, 3'h1, 3'h1, ea};
    endfunction : opw

    function automatic logic cond(input logic [3:0] t, input logic u, input logic z,
                                  input logic n);
        logic [15:0] v = {1'b1, !z, u | z | n, u | (n & !z), u | z | !n, u | !(n | z),
            u | z, u, !u, !(u | z), z | (n & !u), n & !(u | z), z | !(u | n),
            !(u | z | n), z, 1'b0};
        return v[t];
    endfunction : cond

    task automatic do_set(input logic [31:0] op, output int dw, output int dt,
                          output logic [31:0] st);
        int w0;
        int t0;
        wr(OFF_STATUS, 32'h0000fffe);
        wr(OFF_OPWORD, op);
        w0 = we_n;
        t0 = trap_n;
        wr(OFF_CMD, 32'h1);
        rd(OFF_STATUS);
        st = rv;
        dw = we_n - w0;
        dt = trap_n - t0;
    endtask : do_set

    task automatic t_reset();
        rd(OFF_STATUS);
        `CHK("status_rst", 32'h0, rv)
        rd(OFF_RESULT);
        `CHK("result_rst", 32'h0, rv)
        wr(8'h30, 32'hffffffff);
        rd(8'h30);
        `CHK("unmapped", 32'h0, rv)
        `CHK("hresp", 1'b0, hresp)
    endtask : t_reset

    task automatic t_sets();
        logic [3:0] ccs [4] = '{4'h8, 4'h4, 4'h1, 4'h0};
        logic [31:0] st;
        logic e;
        int dw;
        int dt;
        foreach (ccs[i]) begin
            wr(OFF_FPCC, {28'h0, ccs[i]});
            for (int p = 0; p < 32; p++) begin
                e = cond(p[3:0], ccs[i][COND_NAN], ccs[i][COND_Z], ccs[i][COND_N]);
                do_set(opw({3'o0, p[2:0]}, {1'b0, p[4:0]}), dw, dt, st);
                `CHK("set_we", 1, dw)
                `CHK("set_byte", {8{e}}, last_byte)
                rd(OFF_RESULT);
                `CHK("result", {24'h0, {8{e}}}, rv)
                `CHK("unord", ccs[i][COND_NAN] & p[4], st[EXC_UNORD + STAT_EXC_LSB])
                `CHK("acc_iop", ccs[i][COND_NAN] & p[4], st[ACC_IOP + STAT_ACC_LSB])
            end
        end
    endtask : t_sets

    task automatic t_trap();
        logic [31:0] st;
        int dw;
        int dt;
        wr(OFF_CTRL, 32'h1);
        wr(OFF_FPCC, 32'h1);
        do_set(opw(6'o03, 6'h1f), dw, dt, st);
        `CHK("trap_pulse", 1, dt)
        `CHK("trap_nowrite", 0, dw)
        `CHK("trap_sticky", 1'b1, st[STAT_TRAP_BIT])
        `CHK("trap_unord", 1'b1, st[EXC_UNORD + STAT_EXC_LSB])
        dw = we_n;
        u_fpcc_host_model.retry_set();
        rd(OFF_STATUS);
        `CHK("retry_write", 1, we_n - dw)
        `CHK("retry_byte", 8'hff, last_byte)
        wr(OFF_CTRL, 32'h0);
    endtask : t_trap

    task automatic t_illegal();
        logic [5:0] eas [7] = '{6'o10, 6'o72, 6'o73, 6'o74, 6'o71, 6'o70, 6'o57};
        logic [31:0] bad [2] = '{32'h000ff440, 32'h800ff240};
        logic [31:0] st;
        logic ill;
        int dw;
        int dt;
        for (int i = 0; i < 9; i++) begin
            ill = (i < 4) || (i > 6);
            do_set((i < 7) ? opw(eas[i], 6'h0f) : bad[i - 7], dw, dt, st);
            `CHK("illegal", ill, st[STAT_ILL_BIT])
            `CHK("ill_nowrite", ill ? 0 : 1, dw)
            if (!ill) `CHK("dest_ea", eas[i], last_ea)
        end
    endtask : t_illegal

    // low mantissa bytes carry junk that must not reach the quotient
    task automatic dv(input logic [15:0] de, input logic [23:0] dm, input logic [15:0] se,
                      input logic [23:0] sm, input logic [15:0] xe, input logic [23:0] xm,
                      input logic [1:0] xf);
        int n;
        wr(OFF_DST_EXP, {16'h0, de});
        wr(OFF_DST_MAN, {dm, 8'hff});
        wr(OFF_SRC_EXP, {16'h0, se});
        wr(OFF_SRC_MAN, {sm, 8'h5a});
        wr(OFF_STATUS, 32'h0000fffe);
        wr(OFF_CMD, 32'h2);
        n = 0;
        rd(OFF_STATUS);
        // only the normal-operand vectors leave both flags clear
        `CHK("busy_pin", xf == 2'b00, busy)
        while (rv[0] !== 1'b0 && n < 40) begin
            rd(OFF_STATUS);
            n++;
        end
        `CHK("div_done", 1'b0, rv[0])
        `CHK("busy_idle", 1'b0, busy)
        `CHK("div_flags", xf, {rv[EXC_OPND_ERR + 8], rv[EXC_DIV_ZERO + 8]})
        rd(OFF_DST_EXP);
        `CHK("div_exp", {16'h0, xe}, rv)
        rd(OFF_DST_MAN);
        // an infinity carries a zero mantissa
        `CHK("div_man", {xm, 8'h00}, rv)
    endtask : dv

    task automatic t_div();
        dv(16'h4001, 24'hc00000, 16'h4000, 24'h800000, 16'h4000, 24'hc00000, 2'b00);
        dv(16'h3fff, 24'h800000, 16'h4000, 24'hc00000, 16'h3ffd, 24'haaaaab, 2'b00);
        dv(16'h41ff, 24'h800000, 16'h4000, 24'h800000, 16'h41fe, 24'h800000, 2'b00);
        dv(16'hc001, 24'hc00000, 16'h0000, 24'h0, 16'hffff, 24'h0, 2'b01);
        dv(16'h0000, 24'h0, 16'h8000, 24'h0, 16'h7fff, 24'hffffff, 2'b10);
        dv(16'h7fff, 24'h0, 16'hffff, 24'h0, 16'h7fff, 24'hffffff, 2'b10);
    endtask : t_div

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    initial begin
        rst_n = 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_sets();
        t_trap();
        t_illegal();
        t_div();
        conclude();
    end

    // about twenty-five times the expected run
    initial begin
        #200000;
        bad_count++;
        $display("[ERR] watchdog expected done seen hang");
        conclude();
    end
endmodule : fp_cond_divide_tb_top
